//--- core/bpc_pkg.sv
// Shared constants and types of the belt printer print controller
package bpc_pkg;
  // ==========================================================================
  // Clock and timing
  // ==========================================================================
  localparam int CLK_MHZ          = 250;                          // System clock rate
  localparam int POLL_US          = 96;                           // Memory poll interval in us
  localparam int POLL_CYCLES      = POLL_US * CLK_MHZ;            // Poll interval in clocks
  localparam int FAST_LIFT_MS     = 45;                           // Ribbon fast lift in ms
  localparam int FAST_LIFT_CYCLES = FAST_LIFT_MS * 1000 * CLK_MHZ; // Fast lift in clocks
  localparam int LINE_ADV_US      = 8300;                         // Paper advance, 8.3 ms in us
  localparam int LINE_ADV_CYCLES  = LINE_ADV_US * CLK_MHZ;        // Paper advance in clocks
  localparam int CRYSTAL_HZ       = 672000;                       // Logic crystal rate
  localparam int CLK_HZ           = CLK_MHZ * 1000000;            // System clock in Hz
  localparam int MID_HZ           = 84000;                        // First divided rate
  localparam int LOW_HZ           = 220;                          // Lowest divided rate
  localparam int MID_DIV          = CRYSTAL_HZ / MID_HZ;          // Crystal ticks per mid tick
  localparam int LOW_DIV          = CRYSTAL_HZ / LOW_HZ;          // Crystal ticks per low tick
  localparam int MAX_COMPARES     = 8;                            // Compares per finger step
  localparam int MAX_FIRES        = 4;                            // Hammers per finger step

  // ==========================================================================
  // Belt and character codes
  // ==========================================================================
  localparam logic [6:0] BELT_MIN   = 7'h20;   // Count loaded by reference finger
  localparam logic [6:0] BELT_MAX   = 7'h7F;   // Last count before wrap
  localparam logic [7:0] BELT_SPAN  = 8'h60;   // Fingers on the belt
  localparam logic [6:0] LF_CODE    = 7'h0A;   // Line advance character
  localparam logic [6:0] PRINT_LO   = 7'h20;   // First printing code
  localparam logic [6:0] PRINT_HI   = 7'h7E;   // Last printing code

  // ==========================================================================
  // Register map and fields
  // ==========================================================================
  localparam logic [11:0] ENTRY_OFF   = 12'h000; // Write: character entry
  localparam logic [11:0] STATUS_OFF  = 12'h004; // Read: state
  localparam logic [11:0] CONTROL_OFF = 12'h008; // Read/write: control
  localparam int ENTRY_CHAR_LSB  = 0;            // Character code field
  localparam int ENTRY_COL_LSB   = 8;            // Column field
  localparam int CTRL_ENABLE_BIT = 0;            // Print enable
  localparam logic CTRL_ENABLE_RST = 1'b1;       // Print enabled after reset
  localparam logic [1:0] RESP_OKAY   = 2'b00;    // AXI OKAY
  localparam logic [1:0] RESP_SLVERR = 2'b10;    // AXI SLVERR

  // One slot of character plus column memory
  typedef struct packed {
    logic       valid;  // Slot holds a character
    logic       defer;  // Eighth bit: held back until line advance
    logic [6:0] chr;    // Character code
    logic [6:0] col;    // Column number
  } bpc_slot_t;
endpackage

//--- core/bpc_print_ctrl.sv
// Print controller: memory poll, belt counter, compare, hammer, ribbon and line advance
//
// The placing of the registers and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
module bpc_print_ctrl #(
  parameter int DEPTH      = 16,                        // Character memory slots
  parameter int POLL_CYC   = bpc_pkg::POLL_CYCLES,      // Poll interval in clocks
  parameter int LIFT_CYC   = bpc_pkg::FAST_LIFT_CYCLES, // Fast lift length in clocks
  parameter int ADV_CYC    = bpc_pkg::LINE_ADV_CYCLES   // Paper advance length in clocks
) (
  input  wire logic        clk,               // System clock
  input  wire logic        arst_n,            // Async reset, active low
  input  wire logic [11:0] s_axi_awaddr,      // Write address
  input  wire logic        s_axi_awvalid,     // Write address valid
  output logic             s_axi_awready,     // Write address ready
  input  wire logic [31:0] s_axi_wdata,       // Write data
  input  wire logic [3:0]  s_axi_wstrb,       // Write strobes
  input  wire logic        s_axi_wvalid,      // Write data valid
  output logic             s_axi_wready,      // Write data ready
  output logic [1:0]       s_axi_bresp,       // Write response
  output logic             s_axi_bvalid,      // Write response valid
  input  wire logic        s_axi_bready,      // Write response ready
  input  wire logic [11:0] s_axi_araddr,      // Read address
  input  wire logic        s_axi_arvalid,     // Read address valid
  output logic             s_axi_arready,     // Read address ready
  output logic [31:0]      s_axi_rdata,       // Read data
  output logic [1:0]       s_axi_rresp,       // Read response
  output logic             s_axi_rvalid,      // Read data valid
  input  wire logic        s_axi_rready,      // Read data ready
  input  wire logic        even_cell_blocked, // Even photocell dark
  input  wire logic        odd_cell_blocked,  // Odd photocell dark
  output logic             hammer_trigger,    // One-cycle hammer_trigger pulse
  output logic             hammer_odd,        // Hammer_trigger concerns odd position
  output logic [6:0]       hammer_column,     // Column for the column decoder
  output logic             ribbon_fast_lift,  // Ribbon ribbon_fast_lift drive
  output logic             ribbon_sustain,    // Ribbon hold drive
  output logic             line_advance,      // Paper advance request
  output logic             tick_84k,          // 84 kHz enable pulse
  output logic             tick_220           // 220 Hz enable pulse
);
  import bpc_pkg::*;

  localparam int PW = $clog2(DEPTH);  // Slot pointer width

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    bpc_slot_t [DEPTH-1:0] mem;        // Character and column memory
    logic [PW-1:0]  ptr;               // Next slot to poll
    logic [31:0]    poll_cnt;          // Countdown to next poll
    logic [6:0]     belt;              // Finger position count
    logic           prev_even;         // Even cell last cycle
    logic           ref_seen;          // Reference finger in passage
    logic [3:0]     cmp_cnt;           // Compares this finger step
    logic [2:0]     hammer_trigger_cnt;          // Triggers this finger step
    logic           group_odd;         // Parity of this step's group
    logic           enable;            // Print enable
    logic           lf_pending;        // Line advance character seen
    logic           lf_active;         // Paper advance running
    logic [31:0]    lf_cnt;            // Paper advance countdown
    logic [31:0]    lift_cnt;          // Fast lift countdown
    logic           fast_lift;         // Fast lift drive
    logic           sustain;           // Ribbon hold drive
    logic           trig;              // Hammer trigger pulse
    logic           trig_odd;          // Trigger parity
    logic [6:0]     trig_col;          // Trigger column
    logic [27:0]    phase;             // Crystal rate phase accumulator
    logic [2:0]     mid_cnt;           // Crystal ticks toward 84 kHz
    logic [11:0]    low_cnt;           // Crystal ticks toward 220 Hz
    logic           t_mid;             // 84 kHz pulse
    logic           t_low;             // 220 Hz pulse
    logic           aw_got;            // Write address held
    logic [11:0]    aw_addr;           // Held write address
    logic           w_got;             // Write data held
    logic [31:0]    w_data;            // Held write data
    logic [3:0]     w_strb;            // Held strobes
    logic           awready;           // Address ready
    logic           wready;            // Data ready
    logic           bvalid;            // Response valid
    logic [1:0]     bresp;             // Response code
    logic           arready;           // Read address ready
    logic           rvalid;            // Read data valid
    logic [31:0]    rdata;             // Read data
    logic [1:0]     rresp;             // Read response code
  } bpc_state_t;

  bpc_state_t q_ff;        // Registered state
  bpc_state_t nxt_q;       // Next state
  bpc_slot_t  poll_slot;   // Slot read at this poll
  logic       poll_now;    // Poll happens this cycle
  logic       match;       // Compare succeeded
  logic       any_ready;   // Undeferred characters remain
  logic       any_valid;   // Any characters remain
  logic [PW-1:0] free_idx; // Lowest free slot
  logic       free_ok;     // A free slot exists
  logic       both_dark;   // Reference finger present

  // Character under the hammer of a column for a given belt count
  function automatic logic [6:0] finger_chr(input logic [6:0] belt, input logic [6:0] col);
    logic [7:0] s;
    s = {1'b0, belt - BELT_MIN} + {1'b0, col};
    if (s >= BELT_SPAN)
    begin
      s = s - BELT_SPAN;
    end
    if (s >= BELT_SPAN)
    begin
      s = s - BELT_SPAN;
    end
    return s[6:0] + BELT_MIN;
  endfunction

  // ==========================================================================
  // Next state
  // ==========================================================================
  // Whole controller in one pass; later sections may override earlier ones
  always_comb
  begin
    logic [28:0] ph;
    logic [6:0]  wchr;
    ph   = '0;
    wchr = '0;
    nxt_q        = q_ff;
    nxt_q.trig   = 1'b0;
    nxt_q.t_mid  = 1'b0;
    nxt_q.t_low  = 1'b0;
    both_dark    = even_cell_blocked && odd_cell_blocked;

    // Memory scan for free slot and remaining work
    any_ready = 1'b0;
    any_valid = 1'b0;
    free_ok   = 1'b0;
    free_idx  = '0;
    for (int i = DEPTH - 1; i >= 0; i--)
    begin
      if (q_ff.mem[i].valid)
      begin
        any_valid = 1'b1;
        any_ready = any_ready || !q_ff.mem[i].defer;
      end
      else
      begin
        free_ok  = 1'b1;
        free_idx = PW'(i);
      end
    end

    // Crystal rate by phase accumulation, then counted down
    ph = {1'b0, q_ff.phase} + 29'(CRYSTAL_HZ);
    if (ph >= 29'(CLK_HZ))
    begin
      nxt_q.phase = 28'(ph - 29'(CLK_HZ));
      nxt_q.mid_cnt = (q_ff.mid_cnt == 3'(MID_DIV - 1)) ? 3'h0 : q_ff.mid_cnt + 3'h1;
      nxt_q.t_mid   = (q_ff.mid_cnt == 3'(MID_DIV - 1));
      nxt_q.low_cnt = (q_ff.low_cnt == 12'(LOW_DIV - 1)) ? 12'h000 : q_ff.low_cnt + 12'h001;
      nxt_q.t_low   = (q_ff.low_cnt == 12'(LOW_DIV - 1));
    end
    else
    begin
      nxt_q.phase = ph[27:0];
    end

    // Belt counter from photocells; a new finger step restarts compare budget
    nxt_q.prev_even = even_cell_blocked;
    if (both_dark)
    begin
      nxt_q.belt     = BELT_MIN;
      nxt_q.ref_seen = 1'b1;
      nxt_q.cmp_cnt  = '0;
      nxt_q.hammer_trigger_cnt = '0;
    end
    else if (q_ff.prev_even && !even_cell_blocked)
    begin
      // The edge that ends a reference passage is not a finger step
      if (q_ff.ref_seen)
      begin
        nxt_q.ref_seen = 1'b0;
      end
      else
      begin
        nxt_q.belt = (q_ff.belt == BELT_MAX) ? BELT_MIN : q_ff.belt + 7'h01;
      end
      nxt_q.cmp_cnt  = '0;
      nxt_q.hammer_trigger_cnt = '0;
    end

    // Poll timer: one memory access per interval
    poll_now = (q_ff.poll_cnt == '0);
    nxt_q.poll_cnt = poll_now ? 32'(POLL_CYC - 1) : q_ff.poll_cnt - 32'h0000_0001;
    poll_slot = q_ff.mem[q_ff.ptr];

    // Compare; inhibited by ribbon_fast_lift, paper motion, deferral and step budgets
    match = poll_now && q_ff.enable && poll_slot.valid && !poll_slot.defer
            && !q_ff.fast_lift
            && !q_ff.lf_active
            && (q_ff.cmp_cnt < 4'(MAX_COMPARES))
            && (q_ff.hammer_trigger_cnt < 3'(MAX_FIRES))
            && (q_ff.hammer_trigger_cnt == '0 || poll_slot.col[0] == q_ff.group_odd)
            && (finger_chr(q_ff.belt, poll_slot.col) == poll_slot.chr);
    if (poll_now)
    begin
      nxt_q.ptr = (q_ff.ptr == PW'(DEPTH - 1)) ? '0 : q_ff.ptr + PW'(1);
      if (q_ff.cmp_cnt < 4'(MAX_COMPARES) && nxt_q.cmp_cnt == q_ff.cmp_cnt)
      begin
        nxt_q.cmp_cnt = q_ff.cmp_cnt + 4'h1;
      end
    end
    if (match)
    begin
      // Group parity goes to timing; column goes to the decoder to fire one pair
      nxt_q.trig      = 1'b1;
      nxt_q.trig_odd  = poll_slot.col[0];
      nxt_q.trig_col  = poll_slot.col;
      nxt_q.group_odd = poll_slot.col[0];
      nxt_q.hammer_trigger_cnt  = nxt_q.hammer_trigger_cnt + 3'h1;
      nxt_q.mem[q_ff.ptr].valid = 1'b0;
    end

    // Fast lift countdown
    if (q_ff.fast_lift)
    begin
      if (q_ff.lift_cnt == '0)
      begin
        nxt_q.fast_lift = 1'b0;
      end
      else
      begin
        nxt_q.lift_cnt = q_ff.lift_cnt - 32'h0000_0001;
      end
    end
    // Lower the ribbon once nothing is left to print
    if (q_ff.sustain && !q_ff.fast_lift && !any_valid && !q_ff.lf_pending)
    begin
      nxt_q.sustain = 1'b0;
    end

    // Line advance: start when only deferred characters remain
    if (q_ff.lf_pending && !q_ff.lf_active && !any_ready && !match)
    begin
      nxt_q.lf_active = 1'b1;
      nxt_q.lf_cnt    = 32'(ADV_CYC - 1);
    end
    else if (q_ff.lf_active)
    begin
      if (q_ff.lf_cnt == '0)
      begin
        nxt_q.lf_active  = 1'b0;
        nxt_q.lf_pending = 1'b0;
        for (int i = 0; i < DEPTH; i++)
        begin
          nxt_q.mem[i].defer = 1'b0;
        end
      end
      else
      begin
        nxt_q.lf_cnt = q_ff.lf_cnt - 32'h0000_0001;
      end
    end

    // AXI write channels, taken in either order
    if (s_axi_awvalid && q_ff.awready)
    begin
      nxt_q.aw_got  = 1'b1;
      nxt_q.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q_ff.wready)
    begin
      nxt_q.w_got  = 1'b1;
      nxt_q.w_data = s_axi_wdata;
      nxt_q.w_strb = s_axi_wstrb;
    end
    if (q_ff.bvalid && s_axi_bready)
    begin
      nxt_q.bvalid = 1'b0;
    end
    else if (q_ff.aw_got && q_ff.w_got && !q_ff.bvalid)
    begin
      nxt_q.aw_got = 1'b0;
      nxt_q.w_got  = 1'b0;
      nxt_q.bvalid = 1'b1;
      nxt_q.bresp  = RESP_OKAY;
      wchr = q_ff.w_data[ENTRY_CHAR_LSB +: 7];
      if (q_ff.aw_addr[11:2] == ENTRY_OFF[11:2])
      begin
        if (q_ff.w_strb[0] && wchr == LF_CODE)
        begin
          nxt_q.lf_pending = 1'b1; // A second one while pending is dropped
        end
        else if (q_ff.w_strb[0] && wchr >= PRINT_LO && wchr <= PRINT_HI && free_ok)
        begin
          nxt_q.mem[free_idx].valid = 1'b1;
          nxt_q.mem[free_idx].defer = nxt_q.lf_pending;
          nxt_q.mem[free_idx].chr   = wchr;
          nxt_q.mem[free_idx].col   = q_ff.w_data[ENTRY_COL_LSB +: 7];
          if (!q_ff.sustain)
          begin
            nxt_q.fast_lift = 1'b1;
            nxt_q.sustain   = 1'b1;
            nxt_q.lift_cnt  = 32'(LIFT_CYC - 1);
          end
        end
      end
      else if (q_ff.aw_addr[11:2] == CONTROL_OFF[11:2])
      begin
        if (q_ff.w_strb[0])
        begin
          nxt_q.enable = q_ff.w_data[CTRL_ENABLE_BIT];
        end
      end
      else
      begin
        nxt_q.bresp = RESP_SLVERR;
      end
    end
    nxt_q.awready = !nxt_q.aw_got && !nxt_q.bvalid;
    nxt_q.wready  = !nxt_q.w_got && !nxt_q.bvalid;

    // AXI read channel; answer one cycle after the address is taken
    if (q_ff.rvalid && s_axi_rready)
    begin
      nxt_q.rvalid  = 1'b0;
      nxt_q.arready = 1'b1;
    end
    else if (s_axi_arvalid && q_ff.arready)
    begin
      nxt_q.arready = 1'b0;
      nxt_q.rvalid  = 1'b1;
      nxt_q.rresp   = RESP_OKAY;
      nxt_q.rdata   = '0;
      if (s_axi_araddr[11:2] == STATUS_OFF[11:2])
      begin
        nxt_q.rdata = {15'h0000, any_ready, 3'h0, q_ff.ref_seen, !free_ok, q_ff.sustain,
                       q_ff.fast_lift, q_ff.lf_active, q_ff.lf_pending, q_ff.belt};
      end
      else if (s_axi_araddr[11:2] == CONTROL_OFF[11:2])
      begin
        nxt_q.rdata[CTRL_ENABLE_BIT] = q_ff.enable;
      end
      else if (s_axi_araddr[11:2] != ENTRY_OFF[11:2])
      begin
        nxt_q.rresp = RESP_SLVERR;
      end
    end
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  // Reset clears memory; belt starts at its floor until the first reference
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      q_ff          <= '0;
      q_ff.belt     <= BELT_MIN;
      q_ff.enable   <= CTRL_ENABLE_RST;
      q_ff.awready  <= 1'b1;
      q_ff.wready   <= 1'b1;
      q_ff.arready  <= 1'b1;
    end
    else
    begin
      q_ff <= nxt_q;
    end
  end

  // Outputs straight from state flops
  assign hammer_trigger   = q_ff.trig;
  assign hammer_odd       = q_ff.trig_odd;
  assign hammer_column    = q_ff.trig_col;
  assign ribbon_fast_lift = q_ff.fast_lift;
  assign ribbon_sustain   = q_ff.sustain;
  assign line_advance     = q_ff.lf_active;
  assign tick_84k         = q_ff.t_mid;
  assign tick_220         = q_ff.t_low;
  assign s_axi_awready    = q_ff.awready;
  assign s_axi_wready     = q_ff.wready;
  assign s_axi_bvalid     = q_ff.bvalid;
  assign s_axi_bresp      = q_ff.bresp;
  assign s_axi_arready    = q_ff.arready;
  assign s_axi_rvalid     = q_ff.rvalid;
  assign s_axi_rdata      = q_ff.rdata;
  assign s_axi_rresp      = q_ff.rresp;

  // ==========================================================================
  // Checks
  // ==========================================================================
  chk_belt_range: assert property (@(posedge clk) disable iff (!arst_n)
    q_ff.belt >= BELT_MIN) else $error("belt count below floor");
  chk_ref_load: assert property (@(posedge clk) disable iff (!arst_n)
    both_dark |=> q_ff.belt == BELT_MIN) else $error("reference did not load belt");
  chk_belt_step: assert property (@(posedge clk) disable iff (!arst_n)
    (q_ff.prev_even && !even_cell_blocked && !odd_cell_blocked && !q_ff.ref_seen && q_ff.belt != BELT_MAX)
    |=> q_ff.belt == $past(q_ff.belt) + 7'h01) else $error("belt did not advance");
  chk_hammer_trigger_col: assert property (@(posedge clk) disable iff (!arst_n)
    match |=> q_ff.trig && q_ff.trig_col == $past(poll_slot.col) && q_ff.trig_odd == $past(poll_slot.col[0]))
    else $error("trigger not issued for match");
  chk_hammer_trigger_erase: assert property (@(posedge clk) disable iff (!arst_n)
    match |=> !q_ff.mem[$past(q_ff.ptr)].valid) else $error("fired character not erased");
  chk_ribbon_fast_lift_quiet: assert property (@(posedge clk) disable iff (!arst_n)
    q_ff.fast_lift |=> !q_ff.trig) else $error("trigger during fast lift");
  chk_adv_quiet: assert property (@(posedge clk) disable iff (!arst_n)
    q_ff.lf_active |=> !q_ff.trig) else $error("trigger during paper advance");
  chk_hammer_trigger_cap: assert property (@(posedge clk) disable iff (!arst_n)
    q_ff.hammer_trigger_cnt <= 3'(MAX_FIRES) && q_ff.cmp_cnt <= 4'(MAX_COMPARES)) else $error("step budget exceeded");
  chk_lift_pair: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(q_ff.fast_lift) |-> q_ff.sustain) else $error("fast lift without sustain");
  chk_adv_start: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(q_ff.lf_active) |-> !$past(any_ready)) else $error("advance with characters unprinted");
  chk_defer_clear: assert property (@(posedge clk) disable iff (!arst_n)
    $fell(q_ff.lf_active) |-> !any_ready || !q_ff.lf_pending) else $error("deferral not cleared");
  chk_poll_period: assert property (@(posedge clk) disable iff (!arst_n)
    poll_now |=> q_ff.poll_cnt == 32'(POLL_CYC - 1)) else $error("poll period wrong");
  chk_bhold: assert property (@(posedge clk) disable iff (!arst_n)
    q_ff.bvalid && !s_axi_bready |=> q_ff.bvalid) else $error("write response dropped");
  cov_hammer_trigger: cover property (@(posedge clk) disable iff (!arst_n) q_ff.trig);
  cov_multi: cover property (@(posedge clk) disable iff (!arst_n) q_ff.hammer_trigger_cnt == 3'(MAX_FIRES));
  cov_adv_done: cover property (@(posedge clk) disable iff (!arst_n) $fell(q_ff.lf_active));
  cov_ref: cover property (@(posedge clk) disable iff (!arst_n) both_dark);
endmodule // bpc_print_ctrl

//--- tb/bpc_belt_model.sv
// Photocell model of the moving finger belt
`timescale 1ns/1ps
module bpc_belt_model (
  input  wire logic clk,             // System clock
  output logic      even_blk = 1'b0, // Even cell dark
  output logic      odd_blk  = 1'b0  // Odd cell dark
);
  // ==========
  // Reference tab darkens both cells, then n plain fingers cross the even cell
  // One-cycle fingers keep runs short; the design samples the cells every clock
  task automatic sweep(input int n);
    repeat (3) @(posedge clk) {even_blk, odd_blk} <= 2'b11;
    @(posedge clk) {even_blk, odd_blk} <= 2'b00;
    repeat (2 * n) @(posedge clk) even_blk <= ~even_blk;
  endtask
endmodule // bpc_belt_model

//--- tb/belt_printer_print_control_bench.sv
// Self-checking bench of the print controller
`timescale 1ns/1ps
module belt_printer_print_control_bench;
  import bpc_pkg::*;
  // ==========
  logic        clk = 0, arst_n = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0; // Clock, reset, requests
  logic [11:0] awa = 0, ara = 0;                                 // Addresses
  logic [31:0] wd = 0, rdat, seed = 32'h3c79_1c12;               // Data and random state
  logic [1:0]  br, rr;                                           // Responses
  logic        awr, wrd, bv, arr, rv, trig, hodd, lift, sus, adv, even_blk, odd_blk, tk; // Design and belt model outputs
  logic [3:0]  ws = 4'hF;                                        // Write strobes, upper bits random
  int          ticks = 0;                                        // 84 kHz enables seen
  logic [6:0]  hcol, col;                                        // Fired and chosen columns
  logic [33:0] rq[$], hq[$];                                     // Expected notes
  int          error_cnt = 0, checked = 0, cyc = 0, idx[$];      // Counters
  always #2 clk = ~clk;
  bpc_belt_model pm (.clk(clk), .even_blk(even_blk), .odd_blk(odd_blk));
  bpc_print_ctrl #(.POLL_CYC(20), .LIFT_CYC(200), .ADV_CYC(100)) uut (.clk(clk), .arst_n(arst_n),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
    .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr),
    .s_axi_rvalid(rv), .s_axi_rready(rre), .even_cell_blocked(even_blk), .odd_cell_blocked(odd_blk),
    .hammer_trigger(trig), .hammer_odd(hodd), .hammer_column(hcol), .ribbon_fast_lift(lift),
    .ribbon_sustain(sus), .line_advance(adv), .tick_84k(tk), .tick_220());
  // ==========
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Each valid is released at the edge where its ready is seen, each ready where its valid is seen
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
    rq.push_back({e, 32'h0000_0000});
    @(posedge clk);
    {awa, wd, ws, awv, wv, bre} <= {a, d, seed[3:1], 1'b1, 3'b111};
    do
    begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
      if (bv) bre <= 1'b0;
    end while (awv || wv || bre);
  endtask
  task automatic axi_rd(input logic [11:0] a, input logic [33:0] e);
    rq.push_back(e);
    @(posedge clk);
    {ara, arv, rre} <= {a, 2'b11};
    do
    begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
      if (rv) rre <= 1'b0;
    end while (arv || rre);
  endtask
  task automatic end_of_test;
    $display("Checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ==========
  // Watcher: bus answers in order, fired columns matched in any order
  always @(posedge clk)
  begin
    cyc++;
    if (tk) ticks++;
    if (rv && rre) cmp({rr, rdat}, rq.pop_front());
    if (bv && bre) cmp({br, 32'h0000_0000}, rq.pop_front());
    if (trig)
    begin
      idx = hq.find_first_index(x) with (x == {27'h0, hodd, hcol});
      cmp(idx.size(), 1);
      cmp({lift, adv}, 2'b00);
      if (idx.size() != 0) hq.delete(idx[0]);
    end
    if (cyc == 20000)
    begin
      error_cnt++;
      $display("Error %0t: run took too long", $time);
      end_of_test;
    end
  end
  initial
  begin
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    axi_rd(12'h00C, {RESP_SLVERR, 32'h0000_0000});
    pm.sweep(97);
    axi_rd(STATUS_OFF, {RESP_OKAY, 32'h0000_0021});
    pm.sweep(0);
    axi_rd(STATUS_OFF, {RESP_OKAY, 32'h0000_0020});
    // Belt parked at 32, so character 32 plus column matches
    for (int k = 0; k < 5; k++)
    begin
      seed = xs(seed);
      col = 7'(seed % 95);
      hq.push_back({27'h0, col[0], col});
      if (k == 4) axi_wr(ENTRY_OFF, {25'h0, LF_CODE}, RESP_OKAY);
      axi_wr(ENTRY_OFF, {17'h0, col, 1'b0, col + 7'h20}, RESP_OKAY);
    end
    cmp({lift, sus}, 2'b11);
    while (!adv) pm.sweep(0);
    cmp(hq.size(), 1);
    while (hq.size() != 0) pm.sweep(0);
    repeat (30) pm.sweep(0);
    cmp({sus, lift}, 2'b00);
    // The divided enable comes about every 2976 clocks; wait for two of them
    while (ticks < 2) @(posedge clk);
    cmp(ticks, 2);
    end_of_test;
  end
endmodule // belt_printer_print_control_bench
